// ### hdl/ptap_pkg.sv
// Purpose: constants for the point table positioner
// Assumes: apb byte addresses, one word per register
// Notes:   table fields sit behind the index register
package ptap_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_REM_ENTRY = 8'h04;
    localparam logic [7:0] OFS_TBL_INDEX = 8'h08;
    localparam logic [7:0] OFS_TBL_POS   = 8'h0c;
    localparam logic [7:0] OFS_TBL_SPEED = 8'h10;
    localparam logic [7:0] OFS_TBL_ACC   = 8'h14;
    localparam logic [7:0] OFS_TBL_DEC   = 8'h18;
    localparam logic [7:0] OFS_TBL_DWELL = 8'h1c;
    localparam logic [7:0] OFS_TBL_AUX   = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h2c;

    // control register fields
    localparam int CTRL_CMD_MODE_BIT = 0;  // 0 absolute, 1 incremental
    localparam int CTRL_DIR_SEL_BIT  = 1;
    localparam int CTRL_FEED_LSB     = 2;  // two bits wide
    localparam int CTRL_SEL_REG_BIT  = 4;  // entry chosen by register
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // interrupt events: done, table error, move started
    localparam int EV_W     = 3;

    // auxiliary function codes
    localparam logic [1:0] AUX_ABS_SINGLE = 2'h0;
    localparam logic [1:0] AUX_ABS_CHAIN  = 2'h1;
    localparam logic [1:0] AUX_INC_SINGLE = 2'h2;
    localparam logic [1:0] AUX_INC_CHAIN  = 2'h3;

    localparam logic [7:0] LAST_ENTRY = 8'hff;

    // timing: one dwell unit is a millisecond
    localparam int CLK_HZ    = 100_000_000;
    localparam int MS_PER_S  = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LAUNCH, ST_MOVE, ST_DWELL, ST_ZERO
    } ptap_state_t;

endpackage : ptap_pkg

// ### hdl/ptap_sync.sv
// Purpose: two flop synchroniser for remote bits
// Assumes: asynchronous levels
// Notes:   only stage two reads stage one
`timescale 1ns/1ps
module ptap_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // both stages reset to off so nothing starts at release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : ptap_sync

// ### hdl/ptap_dwell_timer.sv
// Purpose: millisecond dwell timer
// Assumes: start is a one cycle pulse
// Notes:   done is a level until the next start
`timescale 1ns/1ps
module ptap_dwell_timer #(
    parameter int MS_CYCLES = ptap_pkg::CYC_PER_MS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [15:0] ms,
    output logic             done
);

    logic [31:0] pre_r;
    logic [15:0] ms_left_r;
    logic        run_r;
    wire         tick = run_r && (pre_r == 32'(MS_CYCLES - 1));

    // prescaler makes one tick per millisecond, then counts them down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r     <= 32'h0;
            ms_left_r <= 16'h0;
            run_r     <= 1'b0;
            done      <= 1'b0;
        end else if (start) begin
            pre_r     <= 32'h0;
            ms_left_r <= ms;
            run_r     <= (ms != 16'h0);
            done      <= (ms == 16'h0);
        end else if (run_r) begin
            pre_r <= tick ? 32'h0 : pre_r + 32'h1;
            if (tick) begin
                ms_left_r <= ms_left_r - 16'h1;
                if (ms_left_r == 16'h1) begin
                    run_r <= 1'b0;
                    done  <= 1'b1;
                end
            end
        end
    end

endmodule : ptap_dwell_timer

// ### hdl/ptap_positioner.sv
// Purpose: point table sequencer
// Assumes: move_done, smooth_zero from the profile generator
// Notes:   table is loaded over apb via an index register
// Function
// - dwell and aux used only for bit selection
// - finish move, wait dwell, then next move
// - aux code zero makes dwell ineffective
// - aux one, dwell zero chains without pause
// - absolute: code 0 single, 1 chains
// - incremental: code 2 single, 3 chains
// - reverse only after smoothed command is zero (checked only between chained entries; a new start launches at once)
// - entry 255 with chain code is error
// - direction parameter swaps rotation sense
// - feed unit scales position by 1..1000
// - forward start launches entry with its profile
// - reverse start ignored in absolute mode
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module ptap_positioner #(
    parameter int MS_CYCLES = ptap_pkg::CYC_PER_MS,
    parameter int ENTRIES   = 256
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          fwd_start_bit,
    input  wire logic          rev_start_bit,
    input  wire logic          auto_manual_select_bit,
    input  wire logic          entry_sel_bit1,
    input  wire logic          entry_sel_bit2,
    input  wire logic          entry_sel_bit3,
    input  wire logic          entry_sel_bit4,
    input  wire logic          entry_sel_bit5,
    input  wire logic          entry_sel_bit6,
    input  wire logic          entry_sel_bit7,
    input  wire logic          entry_sel_bit8,
    input  wire logic          move_done,
    input  wire logic          smooth_zero,
    output logic               move_start,
    output logic signed [41:0] move_target,
    output logic      [15:0]   move_speed,
    output logic      [15:0]   move_acc,
    output logic      [15:0]   move_dec,
    output logic               move_ccw,
    output logic               irq
);

    // table storage
    logic signed [31:0] tbl_pos   [ENTRIES];
    logic [15:0]        tbl_speed [ENTRIES];
    logic [15:0]        tbl_acc   [ENTRIES];
    logic [15:0]        tbl_dec   [ENTRIES];
    logic [15:0]        tbl_dwell [ENTRIES];
    logic [1:0]         tbl_aux   [ENTRIES];

    logic [4:0]            ctrl_r;
    logic [7:0]            rem_entry_r;
    logic [7:0]            tbl_idx_r;
    logic [ptap_pkg::EV_W-1:0] ev_stat_r;
    logic [ptap_pkg::EV_W-1:0] ev_mask_r;
    ptap_pkg::ptap_state_t state_r;
    logic [7:0]            entry_r;
    logic                  by_reg_r;
    logic                  rev_flip_r;
    logic                  cur_pos_dir_r;
    logic signed [41:0]    cur_addr_r;
    logic                  fwd_q_r;
    logic                  rev_q_r;

    // scale position by the feed unit factor
    function automatic logic signed [41:0] feed_scale(
        input logic signed [31:0] pos,
        input logic [1:0]         feed
    );
        logic signed [41:0] p;
        p = 42'(pos);
        case (feed)
            2'h0:    feed_scale = p;
            2'h1:    feed_scale = 42'(p * 42'sd10);
            2'h2:    feed_scale = 42'(p * 42'sd100);
            default: feed_scale = 42'(p * 42'sd1000);
        endcase
    endfunction : feed_scale

    // chaining code for the active command mode
    function automatic logic is_chain(
        input logic [1:0] aux,
        input logic       inc_mode
    );
        is_chain = inc_mode ? (aux == ptap_pkg::AUX_INC_CHAIN)
                            : (aux == ptap_pkg::AUX_ABS_CHAIN);
    endfunction : is_chain

    // synchronised pins
    logic [7:0] sel_s;
    logic       fwd_s;
    logic       rev_s;
    logic       auto_s;

    ptap_sync #(.W(11)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({auto_manual_select_bit, rev_start_bit, fwd_start_bit,
                   entry_sel_bit8, entry_sel_bit7, entry_sel_bit6,
                   entry_sel_bit5, entry_sel_bit4, entry_sel_bit3,
                   entry_sel_bit2, entry_sel_bit1}),
        .q       ({auto_s, rev_s, fwd_s, sel_s})
    );

    // control fields
    wire       inc_mode = ctrl_r[ptap_pkg::CTRL_CMD_MODE_BIT];
    wire       dir_sel  = ctrl_r[ptap_pkg::CTRL_DIR_SEL_BIT];
    wire [1:0] feed     = ctrl_r[ptap_pkg::CTRL_FEED_LSB +: 2];
    wire       sel_reg  = ctrl_r[ptap_pkg::CTRL_SEL_REG_BIT];

    // start detection: edges of the synchronised levels only
    wire fwd_edge  = fwd_s && !fwd_q_r;
    wire rev_edge  = rev_s && !rev_q_r && inc_mode;
    wire start_req = auto_s && (state_r == ptap_pkg::ST_IDLE)
                     && (fwd_edge || rev_edge);
    wire [7:0] start_entry = sel_reg ? rem_entry_r : sel_s;

    // current entry fields
    wire signed [41:0] cur_scaled = feed_scale(tbl_pos[entry_r], feed);
    wire [1:0]  cur_aux   = by_reg_r ? ptap_pkg::AUX_ABS_SINGLE
                                     : tbl_aux[entry_r];
    wire        cur_chain = is_chain(cur_aux, inc_mode);
    wire        cur_dwell = (cur_aux != ptap_pkg::AUX_ABS_SINGLE)
                            && (tbl_dwell[entry_r] != 16'h0);
    wire        bad_last  = !by_reg_r && (entry_r == ptap_pkg::LAST_ENTRY)
                            && (tbl_aux[entry_r] == ptap_pkg::AUX_ABS_CHAIN
                             || tbl_aux[entry_r] == ptap_pkg::AUX_INC_CHAIN);

    // direction of a move in address terms, before the sense parameter
    wire [7:0]         nxt_entry  = entry_r + 8'h1;
    wire signed [41:0] nxt_scaled = feed_scale(tbl_pos[nxt_entry], feed);
    wire signed [41:0] cur_target_after = inc_mode
                            ? 42'(cur_addr_r + cur_scaled) : cur_scaled;
    wire cur_pos_dir = inc_mode ? ((cur_scaled >= 0) ^ rev_flip_r)
                                : (cur_scaled >= cur_addr_r);
    wire nxt_pos_dir = inc_mode ? ((nxt_scaled >= 0) ^ rev_flip_r)
                                : (nxt_scaled >= cur_target_after);
    wire dir_change = (nxt_pos_dir != cur_pos_dir_r);

    // dwell timer
    wire dwell_go = (state_r == ptap_pkg::ST_MOVE) && move_done
                    && cur_chain && cur_dwell;
    logic dwell_done;

    ptap_dwell_timer #(.MS_CYCLES(MS_CYCLES)) u_dwell (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (dwell_go),
        .ms      (tbl_dwell[entry_r]),
        .done    (dwell_done)
    );

    // sequencer next state
    ptap_pkg::ptap_state_t state_nxt;
    wire next_after_move = dir_change;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ptap_pkg::ST_IDLE:
                if (start_req) state_nxt = ptap_pkg::ST_LAUNCH;
            ptap_pkg::ST_LAUNCH:
                state_nxt = bad_last ? ptap_pkg::ST_IDLE
                                     : ptap_pkg::ST_MOVE;
            ptap_pkg::ST_MOVE:
                if (move_done) begin
                    if (!cur_chain)
                        state_nxt = ptap_pkg::ST_IDLE;
                    else if (cur_dwell)
                        state_nxt = ptap_pkg::ST_DWELL;
                    else if (next_after_move)
                        state_nxt = ptap_pkg::ST_ZERO;
                    else
                        state_nxt = ptap_pkg::ST_LAUNCH;
                end
            ptap_pkg::ST_DWELL:
                if (dwell_done && !dwell_go)
                    state_nxt = (cur_pos_dir != cur_pos_dir_r)
                                ? ptap_pkg::ST_ZERO : ptap_pkg::ST_LAUNCH;
            ptap_pkg::ST_ZERO:
                if (smooth_zero) state_nxt = ptap_pkg::ST_LAUNCH;
            default:
                state_nxt = ptap_pkg::ST_IDLE;
        endcase
    end

    wire leave_move = (state_r == ptap_pkg::ST_MOVE) && move_done;
    wire seq_done   = leave_move && !cur_chain;
    wire launch_ok  = (state_r == ptap_pkg::ST_LAUNCH) && !bad_last;
    wire launch_bad = (state_r == ptap_pkg::ST_LAUNCH) && bad_last;

    // sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r       <= ptap_pkg::ST_IDLE;
            entry_r       <= 8'h00;
            by_reg_r      <= 1'b0;
            rev_flip_r    <= 1'b0;
            cur_pos_dir_r <= 1'b1;
            cur_addr_r    <= 42'sh0;
            fwd_q_r       <= 1'b0;
            rev_q_r       <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fwd_q_r <= fwd_s;
            rev_q_r <= rev_s;
            if (start_req) begin
                entry_r    <= start_entry;
                by_reg_r   <= sel_reg;
                rev_flip_r <= !fwd_edge;
            end else if (leave_move && cur_chain) begin
                entry_r <= nxt_entry;
            end
            if (launch_ok) begin
                cur_pos_dir_r <= cur_pos_dir;
                cur_addr_r    <= cur_target_after;
            end
        end
    end

    // move command outputs, held for the profile generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            move_start  <= 1'b0;
            move_target <= 42'sh0;
            move_speed  <= 16'h0;
            move_acc    <= 16'h0;
            move_dec    <= 16'h0;
            move_ccw    <= 1'b0;
        end else begin
            move_start <= launch_ok;
            if (launch_ok) begin
                move_target <= cur_target_after;
                move_speed  <= tbl_speed[entry_r];
                move_acc    <= tbl_acc[entry_r];
                move_dec    <= tbl_dec[entry_r];
                move_ccw    <= cur_pos_dir ^ dir_sel;
            end
        end
    end

    // apb decode
    wire acc_phase = psel && penable;
    wire wr_en     = acc_phase && pwrite;
    wire addr_ok   = (paddr[1:0] == 2'h0)
                     && (paddr <= ptap_pkg::OFS_IRQ_MASK);
    wire wr_ctrl   = wr_en && (paddr == ptap_pkg::OFS_CTRL);
    wire wr_rem    = wr_en && (paddr == ptap_pkg::OFS_REM_ENTRY);
    wire wr_idx    = wr_en && (paddr == ptap_pkg::OFS_TBL_INDEX);
    wire wr_istat  = wr_en && (paddr == ptap_pkg::OFS_IRQ_STAT);
    wire wr_imask  = wr_en && (paddr == ptap_pkg::OFS_IRQ_MASK);

    assign pready  = acc_phase;
    assign pslverr = acc_phase && !addr_ok;

    // table writes; storage carries no reset, software loads it
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == ptap_pkg::OFS_TBL_POS)
            tbl_pos[tbl_idx_r] <= pwdata;
        if (wr_en && paddr == ptap_pkg::OFS_TBL_SPEED)
            tbl_speed[tbl_idx_r] <= pwdata[15:0];
        if (wr_en && paddr == ptap_pkg::OFS_TBL_ACC)
            tbl_acc[tbl_idx_r] <= pwdata[15:0];
        if (wr_en && paddr == ptap_pkg::OFS_TBL_DEC)
            tbl_dec[tbl_idx_r] <= pwdata[15:0];
        if (wr_en && paddr == ptap_pkg::OFS_TBL_DWELL)
            tbl_dwell[tbl_idx_r] <= pwdata[15:0];
        if (wr_en && paddr == ptap_pkg::OFS_TBL_AUX)
            tbl_aux[tbl_idx_r] <= pwdata[1:0];
    end

    // events: set wins over a write-one clear in the same cycle
    wire [ptap_pkg::EV_W-1:0] ev_set = {launch_ok,
                                        launch_bad,
                                        seq_done};
    wire [ptap_pkg::EV_W-1:0] ev_clr =
        wr_istat ? pwdata[ptap_pkg::EV_W-1:0] : '0;

    // control and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r      <= ptap_pkg::CTRL_RESET;
            rem_entry_r <= 8'h00;
            tbl_idx_r   <= 8'h00;
            ev_stat_r   <= '0;
            ev_mask_r   <= '0;
        end else begin
            if (wr_ctrl)  ctrl_r      <= pwdata[4:0];
            if (wr_rem)   rem_entry_r <= pwdata[7:0];
            if (wr_idx)   tbl_idx_r   <= pwdata[7:0];
            if (wr_imask) ev_mask_r   <= pwdata[ptap_pkg::EV_W-1:0];
            ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(ev_stat_r & ev_mask_r);

    // read mux; captured in the setup phase so prdata is a flop
    wire [3:0] st_bits = {cur_pos_dir_r ^ dir_sel,
                          state_r == ptap_pkg::ST_ZERO,
                          state_r == ptap_pkg::ST_DWELL,
                          state_r != ptap_pkg::ST_IDLE};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (paddr)
            ptap_pkg::OFS_CTRL:      rd_mux = 32'(ctrl_r);
            ptap_pkg::OFS_REM_ENTRY: rd_mux = 32'(rem_entry_r);
            ptap_pkg::OFS_TBL_INDEX: rd_mux = 32'(tbl_idx_r);
            ptap_pkg::OFS_TBL_POS:   rd_mux = tbl_pos[tbl_idx_r];
            ptap_pkg::OFS_TBL_SPEED: rd_mux = 32'(tbl_speed[tbl_idx_r]);
            ptap_pkg::OFS_TBL_ACC:   rd_mux = 32'(tbl_acc[tbl_idx_r]);
            ptap_pkg::OFS_TBL_DEC:   rd_mux = 32'(tbl_dec[tbl_idx_r]);
            ptap_pkg::OFS_TBL_DWELL: rd_mux = 32'(tbl_dwell[tbl_idx_r]);
            ptap_pkg::OFS_TBL_AUX:   rd_mux = 32'(tbl_aux[tbl_idx_r]);
            ptap_pkg::OFS_STATUS:    rd_mux = {16'h0, entry_r, 4'h0, st_bits};
            ptap_pkg::OFS_IRQ_STAT:  rd_mux = 32'(ev_stat_r);
            ptap_pkg::OFS_IRQ_MASK:  rd_mux = 32'(ev_mask_r);
            default:                 rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable)
            prdata <= rd_mux;
    end

endmodule : ptap_positioner

// ### sim/ptap_positioner_properties.sv
// Purpose: port checks for the point table positioner
// Assumes: zero wait apb, registered motion outputs
// Notes:   bound from the bench file
`timescale 1ns/1ps
module ptap_positioner_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        smooth_zero,
    input wire logic        move_start,
    input wire logic [15:0] move_speed,
    input wire logic [15:0] move_acc,
    input wire logic        move_ccw,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // access, write and refused address
    wire acc = psel && penable;
    wire wr  = acc && pwrite;
    wire bad = (paddr > 8'h2c) || (paddr[1:0] != 2'h0);

    a_ready_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access");
    a_ready_idle: assert property (!psel |-> !pready)
        else $error("pready without psel");
    a_err_decode: assert property (pslverr == (acc && bad))
        else $error("pslverr wrong");
    a_read_bad_zero: assert property (acc && !pwrite && bad |-> prdata == 0)
        else $error("refused read data");
    a_start_single: assert property (move_start |=> !move_start)
        else $error("move_start too long");
    // fields move only with a launch
    a_fields_hold: assert property (!move_start |->
        $stable(move_speed) && $stable(move_acc) && $stable(move_ccw))
        else $error("fields moved without launch");
    // irq drops only through a write
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without write");
    a_reverse_zero: assert property (move_start &&
        move_ccw != $past(move_ccw) |-> $past(smooth_zero))
        else $error("reversed before zero");
endmodule : ptap_positioner_properties

// ### sim/ptap_profile_model.sv
// Purpose: profile generator stand-in
// Assumes: one move at a time, same clock
// Notes:   smooth_zero lags move_done like a ramp
`timescale 1ns/1ps
module ptap_profile_model #(
    parameter int MOVE_CYC = 20,
    parameter int ZERO_CYC = 15
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic move_start,
    output logic      move_done,
    output logic      smooth_zero
);
    int cnt_r;  // cycles since launch, zero at rest

    // done pulses after the move; zero only after the ramp settles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r       <= 0;
            move_done   <= 1'b0;
            smooth_zero <= 1'b1;
        end else begin
            move_done <= (cnt_r == MOVE_CYC);
            if (move_start) begin
                cnt_r       <= 1;
                smooth_zero <= 1'b0;
            end else if (cnt_r == MOVE_CYC + ZERO_CYC) begin
                cnt_r       <= 0;
                smooth_zero <= 1'b1;
            end else if (cnt_r != 0) begin
                cnt_r <= cnt_r + 1;
            end
        end
    end
endmodule : ptap_profile_model

// ### sim/ptap_positioner_tb_top.sv
// Purpose: self checking bench for the positioner
// Assumes: a millisecond scaled to 10 cycles
// Notes:   entries are loaded over apb before starts
`timescale 1ns/1ps
module ptap_positioner_tb_top;
    localparam int MV = 20;  // model move cycles
    localparam int ZC = 15;  // model settle cycles
    logic               pclk = 1'b0, presetn = 1'b0, fwd = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [7:0]         sel = 8'h00;
    logic               rev = 1'b0, auto_on = 1'b0;
    logic [31:0]        prdata;
    logic               pready, pslverr, mdone, szero, mstart, ccw, irq;
    logic signed [41:0] tgt;
    logic [15:0]        spd, acc, dec;
    int                 error_cnt = 0;
    int                 compares = 0;

    always #5 pclk = ~pclk;

    ptap_positioner #(.MS_CYCLES(10)) i_ptap_positioner (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fwd_start_bit(fwd),
        .rev_start_bit(rev), .auto_manual_select_bit(auto_on),
        .entry_sel_bit1(sel[0]), .entry_sel_bit2(sel[1]),
        .entry_sel_bit3(sel[2]), .entry_sel_bit4(sel[3]),
        .entry_sel_bit5(sel[4]), .entry_sel_bit6(sel[5]),
        .entry_sel_bit7(sel[6]), .entry_sel_bit8(sel[7]),
        .move_done(mdone), .smooth_zero(szero), .move_start(mstart),
        .move_target(tgt), .move_speed(spd), .move_acc(acc),
        .move_dec(dec), .move_ccw(ccw), .irq);

    ptap_profile_model #(.MOVE_CYC(MV), .ZERO_CYC(ZC)) i_ptap_profile_model (
        .pclk, .presetn, .move_start(mstart),
        .move_done(mdone), .smooth_zero(szero));

    task automatic end_sim();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string s, input logic [63:0] x, g);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", s, x, g);
        end
    endtask : chk

    task automatic to(input string s);
        chk(s, 64'h1, 64'h0);
        end_sim();
    endtask : to

    // one apb transfer; an idle edge after it keeps drivers apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 9) to("pready");
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic ent(input logic [7:0] i, input int p,
                       input logic [15:0] dw, input logic [1:0] ax);
        wr(ptap_pkg::OFS_TBL_INDEX, {24'h0, i});
        wr(ptap_pkg::OFS_TBL_POS, 32'(p));
        wr(ptap_pkg::OFS_TBL_SPEED, 32'h0123);
        wr(ptap_pkg::OFS_TBL_ACC, 32'h0124);
        wr(ptap_pkg::OFS_TBL_DEC, 32'h0125);
        wr(ptap_pkg::OFS_TBL_DWELL, {16'h0, dw});
        wr(ptap_pkg::OFS_TBL_AUX, {30'h0, ax});
    endtask : ent

    // wait for a launch pulse; ends the run if one must come
    task automatic ws(input int lim, input bit must, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (mstart !== 1'b1 && n < lim);
        if (must && mstart !== 1'b1) to("move_start");
    endtask : ws

    task automatic go(input logic [7:0] e, input bit must, output int n);
        sel     <= e;
        auto_on <= 1'b1;
        @(posedge pclk);
        fwd <= 1'b1;
        ws(40, must, n);
        fwd <= 1'b0;
    endtask : go

    task automatic idle();
        logic [31:0] q;
        logic        e;
        int          n = 0;
        do begin
            apb(1'b0, ptap_pkg::OFS_STATUS, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 30);
        if (n >= 30) to("busy");
    endtask : idle

    task automatic t_launch();
        int n;
        ent(8'ha5, 100, 16'h0, ptap_pkg::AUX_ABS_SINGLE);
        for (int f = 0; f < 4; f++) begin
            wr(ptap_pkg::OFS_CTRL, 32'(f << 2));
            go(8'ha5, 1'b1, n);
            chk("target", 64'(100 * 10 ** f), 64'(tgt));
            chk("speed", 64'h0123, 64'(spd));
            chk("acc dec", 64'h01240125, 64'({acc, dec}));
            chk("ccw", 64'h1, 64'(ccw));
            idle();
        end
        wr(ptap_pkg::OFS_CTRL, 32'h0000000e);
        repeat (ZC) @(posedge pclk);  // ramp settles before a reversal
        go(8'ha5, 1'b1, n);
        chk("ccw dir1", 64'h0, 64'(ccw));
        idle();
    endtask : t_launch

    task automatic t_chain();
        int          n;
        int          p[4] = '{900, 500, 100, 700};
        logic [1:0]  ax[4] = '{2'h1, 2'h1, 2'h1, 2'h0};
        logic [15:0] dw[4] = '{16'h3, 16'h0, 16'h0, 16'h5};
        wr(ptap_pkg::OFS_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) ent(8'(10 + i), p[i], dw[i], ax[i]);
        go(8'h0a, 1'b1, n);
        chk("chain ccw", 64'h0, 64'(ccw));
        ws(80, 1'b1, n);
        chk("dwell", 64'h1, 64'(n >= MV + 30 && n <= MV + 40));
        ws(80, 1'b1, n);
        chk("no pause", 64'h1, 64'(n <= MV + 6));
        ws(80, 1'b1, n);
        chk("zero wait", 64'h1, 64'(n >= MV + ZC && n <= MV + ZC + 8));
        chk("chain target", 64'd700, 64'(tgt));
        ws(150, 1'b0, n);
        chk("single end", 64'h0, 64'(mstart));
    endtask : t_chain

    task automatic t_err();
        int          n;
        logic [31:0] q;
        logic        e;
        wr(ptap_pkg::OFS_IRQ_MASK, 32'h0);
        for (int a = 1; a < 4; a += 2) begin
            ent(8'hff, 10, 16'h0, 2'(a));
            wr(ptap_pkg::OFS_IRQ_STAT, 32'h7);
            go(8'hff, 1'b0, n);
            chk("err start", 64'h0, 64'(mstart));
            apb(1'b0, ptap_pkg::OFS_IRQ_STAT, 32'h0, q, e);
            chk("err flag", 64'h1, 64'(q[1]));
            chk("irq masked", 64'h0, 64'(irq));
        end
        wr(ptap_pkg::OFS_IRQ_MASK, 32'h2);
        chk("irq on", 64'h1, 64'(irq));
        wr(ptap_pkg::OFS_IRQ_STAT, 32'h2);
        chk("irq clear", 64'h0, 64'(irq));
    endtask : t_err

    task automatic t_ignore();
        int          n;
        logic [31:0] q;
        logic        e;
        sel <= 8'h0a;
        rev <= 1'b1;
        ws(40, 1'b0, n);
        chk("rev start", 64'h0, 64'(mstart));
        rev     <= 1'b0;
        auto_on <= 1'b0;
        fwd     <= 1'b1;
        ws(40, 1'b0, n);
        chk("manual start", 64'h0, 64'(mstart));
        fwd <= 1'b0;
        wr(ptap_pkg::OFS_REM_ENTRY, 32'h0a);
        wr(ptap_pkg::OFS_CTRL, 32'h10);
        go(8'h00, 1'b1, n);
        chk("reg target", 64'd900, 64'(tgt));
        ws(150, 1'b0, n);
        chk("reg single", 64'h0, 64'(mstart));
        apb(1'b0, 8'h30, 32'h0, q, e);
        chk("unmapped err", 64'h1, 64'(e));
        chk("unmapped data", 64'h0, 64'(q));
    endtask : t_ignore

    // reset for 12 cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_launch();
        t_chain();
        t_err();
        t_ignore();
        end_sim();
    end
endmodule : ptap_positioner_tb_top

bind ptap_positioner ptap_positioner_properties i_ptap_positioner_properties
    (.*);
